// ==== rtl/msia_arbiter.v ====
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Ports served fixed priority, port 0 first
// RL2: Lowest pending adapter wins, loads its port
// RL3: One read gives adapter, port, type
// RL4: Host reads 16-bit register at 0130
// RL5: Up to eight adapters arbitrate together
// RL6: Eight selectable IRQ outputs: 3..15
// RL7: Setup picks one line; only it driven
// RL8: Open-collector: pull low, else release
// RL9: Host should give all adapters one level
// RL10: Data lines: mark is 1, space 0
// RL11: Control lines: space on, mark off
// RL12: Undriven receiver presents mark, binary 1
// RL13: Ports carry TxD, RxD, DCD, DTR
// RL14: Rx, tx-empty, line status separately enabled
// RL15: Nothing pending: release line, report none
`include "msia_consts.vh"

module msia_arbiter
(
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // System I/O read port
  input wire [15:0] ioAddr,
  input wire ioRd,
  output reg [15:0] ioRdData,
  output reg ioRdOe,
  // Slot setup register write
  input wire setupWr,
  input wire [7:0] setupData,
  // Channel interrupt sources and enables
  input wire [15:0] chRxAvail,
  input wire [15:0] chTxEmpty,
  input wire [15:0] chLineStat,
  input wire [15:0] chIeRx,
  input wire [15:0] chIeTx,
  input wire [15:0] chIeLs,
  // Shared interrupt request lines, open collector
  output reg [7:0] irqOut,
  output reg [7:0] irqOe,
  // Inter-adapter arbitration lines, open collector, low when pending
  input wire [7:0] arbIn,
  output reg [7:0] arbOut,
  output reg [7:0] arbOe,
  // Channel side of the serial lines
  input wire [15:0] chTxBit,
  input wire [15:0] chDtrOn,
  output reg [15:0] chRxBit,
  output reg [15:0] chDcdOn,
  // Serial line pins, logic levels
  output reg [15:0] txdLine,
  output reg [15:0] dtrLine,
  input wire [15:0] rxdLine,
  input wire [15:0] dcdLine,
  input wire [15:0] rxOpen
);

  // Setup state
  reg [7:0] setup_reg;
  // Per-port pending and type
  wire [15:0] chPend;
  wire [31:0] chType;
  // Port winner
  wire [3:0] portIdx;
  wire portFound;
  reg [1:0] winType;
  // Source register
  reg [15:0] src_reg;
  reg [15:0] src_next;
  // Arbitration line synchronisers
  reg [7:0] arbMeta_reg;
  reg [7:0] arbSync_reg;
  reg [7:0] higherMask;
  wire [2:0] myId;
  wire anyOther;
  wire iWin;
  wire answer;
  // Serial pin synchronisers
  reg [15:0] rxdMeta_reg;
  reg [15:0] rxdSync_reg;
  reg [15:0] dcdMeta_reg;
  reg [15:0] dcdSync_reg;
  reg [15:0] openMeta_reg;
  reg [15:0] openSync_reg;
  // Separate loop indices keep the combinational blocks from waking each other
  integer j;
  integer k;
  integer m;

  assign myId = setup_reg[`MSIA_SET_ID_MSB:`MSIA_SET_ID_LSB];

  // Slot setup register; irq line and adapter slot id
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      setup_reg <= `MSIA_SET_RST;
    else if (setupWr)
      setup_reg <= setupData; // see RL7
  end

  // Per-port enabled sources and type, line status ranks over rx and tx
  genvar g;
  generate
    for (g = 0; g < `MSIA_PORTS; g = g + 1)
    begin : gPort
      wire ls;
      wire rx;
      wire tx;
      assign ls = chLineStat[g] & chIeLs[g]; // see RL14
      assign rx = chRxAvail[g] & chIeRx[g]; // see RL14
      assign tx = chTxEmpty[g] & chIeTx[g]; // see RL14
      assign chPend[g] = ls | rx | tx;
      assign chType[2*g+1:2*g] = ls ? `MSIA_TYPE_LINE :
                                 rx ? `MSIA_TYPE_RXAV :
                                 tx ? `MSIA_TYPE_TXEM : `MSIA_TYPE_NONE;
    end
  endgenerate

  // Lowest numbered pending port is the one reported
  msia_prio_enc uPortEnc
  (
    .req(chPend), // see RL1
    .idx(portIdx),
    .found(portFound)
  );

  // Type of the winning port
  always @*
  begin
    winType = `MSIA_TYPE_NONE;
    for (j = 0; j < `MSIA_PORTS; j = j + 1)
    begin
      if (portIdx == j[3:0])
        winType = chType[2*j+1 -: 2];
    end
  end

  // Mask of adapter slots ranked above this one
  always @*
  begin
    higherMask = 8'h00;
    for (k = 0; k < `MSIA_ADAPTERS; k = k + 1)
    begin
      if (k[2:0] < myId)
        higherMask[k] = 1'b1;
    end
  end

  // Other adapters signal pending by pulling their own slot line low
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arbMeta_reg <= 8'h00;
      arbSync_reg <= 8'h00;
    end
    else
    begin
      arbMeta_reg <= ~arbIn;
      arbSync_reg <= arbMeta_reg;
    end
  end

  // A lower-numbered slot pending means this adapter loses the read
  assign anyOther = |(arbSync_reg & higherMask); // see RL5
  assign iWin = portFound & ~anyOther; // see RL2
  // Slot 0 answers the empty report when no other adapter is pending;
  // its own line is skipped, it lags the local state by three cycles
  assign answer = iWin | (~portFound & ~(|arbSync_reg[7:1]) & (myId == 3'h0)); // see RL15

  // Source register tracks the winner every cycle
  always @*
  begin
    src_next = `MSIA_SRC_RST; // see RL15
    if (portFound)
    begin
      src_next[`MSIA_SRC_VALID] = 1'b1;
      src_next[`MSIA_SRC_PORT_MSB:`MSIA_SRC_PORT_LSB] = portIdx; // see RL3
      src_next[`MSIA_SRC_ADAPT_MSB:`MSIA_SRC_ADAPT_LSB] = myId; // see RL3
      src_next[`MSIA_SRC_TYPE_MSB:`MSIA_SRC_TYPE_LSB] = winType; // see RL3
    end
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      src_reg <= `MSIA_SRC_RST;
    else
      src_reg <= src_next; // see RL2
  end

  // Read answer one cycle after the strobe; losers keep off the bus
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ioRdData <= 16'h0000;
      ioRdOe <= 1'b0;
    end
    else if (ioRd && ioAddr == `MSIA_SRC_ADDR && answer)
    begin
      ioRdData <= src_reg; // see RL4
      ioRdOe <= 1'b1;
    end
    else
    begin
      ioRdData <= 16'h0000;
      ioRdOe <= 1'b0;
    end
  end

  // Interrupt and arbitration lines; the driven level is always low
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqOut <= 8'h00;
      irqOe <= 8'h00;
      arbOut <= 8'h00;
      arbOe <= 8'h00;
    end
    else
    begin
      irqOut <= 8'h00; // see RL8
      arbOut <= 8'h00;
      for (m = 0; m < `MSIA_IRQ_LINES; m = m + 1)
      begin
        // Index 0..7 maps to levels 3,5,9,10,11,12,14,15
        irqOe[m] <= setup_reg[`MSIA_SET_EN] & portFound // see RL15
                    & (setup_reg[`MSIA_SET_IRQ_MSB:`MSIA_SET_IRQ_LSB] == m[2:0]); // see RL6
        arbOe[m] <= portFound & (myId == m[2:0]); // see RL5
      end
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxdMeta_reg <= 16'hFFFF;
      rxdSync_reg <= 16'hFFFF;
      dcdMeta_reg <= 16'hFFFF;
      dcdSync_reg <= 16'hFFFF;
      openMeta_reg <= 16'h0000;
      openSync_reg <= 16'h0000;
    end
    else
    begin
      rxdMeta_reg <= rxdLine;
      rxdSync_reg <= rxdMeta_reg;
      dcdMeta_reg <= dcdLine;
      dcdSync_reg <= dcdMeta_reg;
      openMeta_reg <= rxOpen;
      openSync_reg <= openMeta_reg;
    end
  end

  // Line level mapping; reset shows idle mark and control off
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chRxBit <= 16'hFFFF;
      chDcdOn <= 16'h0000;
      txdLine <= 16'hFFFF;
      dtrLine <= 16'hFFFF;
    end
    else
    begin
      chRxBit <= rxdSync_reg | openSync_reg; // see RL10 see RL12 see RL13
      chDcdOn <= ~dcdSync_reg; // see RL11
      txdLine <= chTxBit; // see RL10
      dtrLine <= ~chDtrOn; // see RL11
    end
  end

endmodule // msia_arbiter

// ==== rtl/msia_consts.vh ====
`ifndef MSIA_CONSTS_VH
`define MSIA_CONSTS_VH

// Fixed I/O address of the interrupt source register
`define MSIA_SRC_ADDR 16'h0130

// Interrupt source register fields
`define MSIA_SRC_PORT_LSB 0
`define MSIA_SRC_PORT_MSB 3
`define MSIA_SRC_ADAPT_LSB 4
`define MSIA_SRC_ADAPT_MSB 6
`define MSIA_SRC_TYPE_LSB 8
`define MSIA_SRC_TYPE_MSB 9
`define MSIA_SRC_VALID 15
`define MSIA_SRC_RST 16'h0000

// Interrupt type codes, line status ranks first
`define MSIA_TYPE_NONE 2'h0
`define MSIA_TYPE_LINE 2'h1
`define MSIA_TYPE_RXAV 2'h2
`define MSIA_TYPE_TXEM 2'h3

// Slot setup register fields
`define MSIA_SET_IRQ_LSB 0
`define MSIA_SET_IRQ_MSB 2
`define MSIA_SET_ID_LSB 3
`define MSIA_SET_ID_MSB 5
`define MSIA_SET_EN 6
`define MSIA_SET_RST 8'h00

// Sizes
`define MSIA_PORTS 16
`define MSIA_ADAPTERS 8
`define MSIA_IRQ_LINES 8

`endif

// ==== rtl/msia_prio_enc.v ====
`timescale 1ns/1ps
// Fixed priority encoder, index 0 wins
module msia_prio_enc
(
  // Request vector
  input wire [15:0] req,
  // Winner
  output reg [3:0] idx,
  output reg found
);

  integer i;

  // Scan from the top down so the lowest index is written last
  always @*
  begin
    idx = 4'h0;
    found = 1'b0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        idx = i[3:0];
        found = 1'b1;
      end
    end
  end

endmodule // msia_prio_enc

// ==== tb/msia_arbiter_properties.sv ====
`timescale 1ns/1ps
module msia_arbiter_properties
(
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Register read
  input wire [15:0] ioAddr,
  input wire ioRd,
  input wire [15:0] ioRdData,
  input wire ioRdOe,
  // Sources
  input wire [15:0] chRxAvail,
  input wire [15:0] chTxEmpty,
  input wire [15:0] chLineStat,
  input wire [15:0] chIeRx,
  input wire [15:0] chIeTx,
  input wire [15:0] chIeLs,
  // Shared lines
  input wire [7:0] irqOut,
  input wire [7:0] irqOe,
  input wire [7:0] arbOut,
  input wire [7:0] arbOe,
  // Serial
  input wire [15:0] chTxBit,
  input wire [15:0] chDtrOn,
  input wire [15:0] chRxBit,
  input wire [15:0] txdLine,
  input wire [15:0] dtrLine,
  input wire [15:0] rxOpen
);
  // Any enabled source on this adapter
  wire pend = |(chRxAvail & chIeRx | chTxEmpty & chIeTx | chLineStat & chIeLs);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Read strobe at the fixed address
  sequence s_rd;
    ioRd && ioAddr == 16'h0130;
  endsequence
  a_read_once: assert property (s_rd ##1 !ioRd |=> !ioRdOe)
    else $error("read answer stands too long");
  a_stray_read: assert property (!(ioRd && ioAddr == 16'h0130) |=> !ioRdOe)
    else $error("answer without a read");
  a_idle_data: assert property (!ioRdOe |-> ioRdData == 16'h0000)
    else $error("data while not answering");
  a_open_coll: assert property (irqOut == 8'h00 && arbOut == 8'h00)
    else $error("shared line driven high");
  a_one_line: assert property ($onehot0(irqOe))
    else $error("more than one line pulled");
  a_quiet_line: assert property (!pend |=> irqOe == 8'h00)
    else $error("line pulled with nothing pending");
  a_arb_follow: assert property ($past(pend) ? $onehot(arbOe) : arbOe == 8'h00)
    else $error("arbitration line wrong");
  a_tx_pass: assert property (txdLine == $past(chTxBit))
    else $error("transmit data wrong");
  a_dtr_inv: assert property (dtrLine == ~$past(chDtrOn))
    else $error("control polarity wrong");
  a_rx_failsafe: assert property (($past(rxOpen, 3) & ~chRxBit) == 16'h0000)
    else $error("open receiver not mark");
endmodule // msia_arbiter_properties
bind msia_arbiter msia_arbiter_properties chk
(
  .ref_clk(ref_clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioRd(ioRd), .ioRdData(ioRdData),
  .ioRdOe(ioRdOe), .chRxAvail(chRxAvail), .chTxEmpty(chTxEmpty), .chLineStat(chLineStat),
  .chIeRx(chIeRx), .chIeTx(chIeTx), .chIeLs(chIeLs), .irqOut(irqOut), .irqOe(irqOe),
  .arbOut(arbOut), .arbOe(arbOe), .chTxBit(chTxBit), .chDtrOn(chDtrOn), .chRxBit(chRxBit),
  .txdLine(txdLine), .dtrLine(dtrLine), .rxOpen(rxOpen)
);

// ==== tb/msia_host_model.sv ====
`timescale 1ns/1ps
module msia_host_model
(
  // Clock and answers
  input wire ref_clk,
  input wire [15:0] ioRdData,
  input wire ioRdOe,
  input wire [7:0] irqOut,
  input wire [7:0] irqOe,
  // Requests
  output logic [15:0] ioAddr,
  output logic ioRd,
  output logic setupWr,
  output logic [7:0] setupData,
  // Lines after the pull-up
  output wire [7:0] irqLine
);
  // Released line floats up to the pull-up; a driven line shows its level
  assign irqLine = irqOut | ~irqOe;
  // Idle bus
  initial
  begin
    ioAddr = 16'h0000;
    ioRd = 1'b0;
    setupWr = 1'b0;
    setupData = 8'h00;
  end
  // One-cycle strobe; answer stands the next cycle
  task rd(input [15:0] a, output [15:0] d, output o);
    @(negedge ref_clk);
    ioRd = 1'b1;
    ioAddr = a;
    @(negedge ref_clk);
    ioRd = 1'b0;
    ioAddr = ~a;
    d = ioRdData;
    o = ioRdOe;
  endtask
  // Every adapter gets the same level
  task setup(input [7:0] v);
    @(negedge ref_clk);
    setupWr = 1'b1;
    setupData = v;
    @(negedge ref_clk);
    setupWr = 1'b0;
    setupData = ~v;
  endtask
endmodule // msia_host_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] chRxAvail = 0, chTxEmpty = 0, chLineStat = 0, chIeRx = 0, chIeTx = 0;
  logic [15:0] chIeLs = 0, chTxBit = 16'hFFFF, chDtrOn = 0, rxdLine = 16'hFFFF;
  logic [15:0] dcdLine = 16'hFFFF, rxOpen = 0, d;
  logic [7:0] others = 8'hFF;
  logic o;
  wire [15:0] ioAddr, ioRdData, chRxBit, chDcdOn, txdLine, dtrLine;
  wire ioRd, ioRdOe, setupWr;
  wire [7:0] setupData, irqOut, irqOe, irqLine, arbOut, arbOe;
  // Wired-AND of the arbitration lines
  wire [7:0] arbIn = others & (arbOut | ~arbOe);
  int errTotal = 0, checksDone = 0, cyc = 0;
  msia_arbiter dut
  (
    .ref_clk(ref_clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioRd(ioRd), .ioRdData(ioRdData),
    .ioRdOe(ioRdOe), .setupWr(setupWr), .setupData(setupData), .chRxAvail(chRxAvail),
    .chTxEmpty(chTxEmpty), .chLineStat(chLineStat), .chIeRx(chIeRx), .chIeTx(chIeTx),
    .chIeLs(chIeLs), .irqOut(irqOut), .irqOe(irqOe), .arbIn(arbIn), .arbOut(arbOut),
    .arbOe(arbOe), .chTxBit(chTxBit), .chDtrOn(chDtrOn), .chRxBit(chRxBit),
    .chDcdOn(chDcdOn), .txdLine(txdLine), .dtrLine(dtrLine), .rxdLine(rxdLine),
    .dcdLine(dcdLine), .rxOpen(rxOpen)
  );
  msia_host_model host
  (
    .ref_clk(ref_clk), .ioRdData(ioRdData), .ioRdOe(ioRdOe), .irqOut(irqOut), .irqOe(irqOe),
    .ioAddr(ioAddr), .ioRd(ioRd), .setupWr(setupWr), .setupData(setupData), .irqLine(irqLine)
  );
  // Clock
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task chk(input [15:0] g, input [15:0] e);
    checksDone++;
    if (g !== e)
    begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rdChk(input [15:0] e, input oe);
    host.rd(16'h0130, d, o);
    chk(d, e);
    chk({15'h0000, o}, {15'h0000, oe});
  endtask
  task tIdle;
    rdChk(16'h0000, 1'b1);
    host.rd(16'h0120, d, o);
    chk({15'h0000, o}, 16'h0000);
    $display("idle done");
  endtask
  task tLines;
    chRxAvail = 16'h0001;
    chIeRx = 16'hFFFF;
    for (int i = 0; i < 8; i++)
    begin
      host.setup(8'h40 | i[7:0]);
      repeat (2) @(negedge ref_clk);
      chk({8'h00, irqLine}, {8'h00, ~(8'h01 << i)});
    end
    // Enable bit clear: pending source must leave every line released
    host.setup(8'h07);
    repeat (2) @(negedge ref_clk);
    chk({8'h00, irqLine}, 16'h00FF);
    host.setup(8'h40);
    $display("lines done");
  endtask
  task tPrio;
    chRxAvail = 16'h0220;
    chLineStat = 16'h0200;
    chIeLs = 16'hFFFF;
    rdChk(16'h8205, 1'b1);
    chRxAvail = 16'h0200;
    rdChk(16'h8109, 1'b1);
    chRxAvail = 0;
    chLineStat = 0;
    chTxEmpty = 16'h8000;
    chIeTx = 16'h8000;
    rdChk(16'h830F, 1'b1);
    chIeTx = 0;
    rdChk(16'h0000, 1'b1);
    chk({8'h00, irqLine}, 16'h00FF);
    $display("prio done");
  endtask
  task tArb;
    host.setup(8'h50);
    chRxAvail = 16'h0008;
    others = 8'hFD;
    repeat (4) @(negedge ref_clk);
    chk({8'h00, arbOe}, 16'h0004);
    rdChk(16'h0000, 1'b0);
    others = 8'hDF;
    repeat (4) @(negedge ref_clk);
    rdChk(16'h8223, 1'b1);
    $display("arb done");
  endtask
  task tSerial;
    chTxBit = 16'hA5C3;
    chDtrOn = 16'h00FF;
    rxdLine = 16'h1234;
    dcdLine = 16'h0F0F;
    rxOpen = 16'h00C0;
    repeat (4) @(negedge ref_clk);
    chk(txdLine, 16'hA5C3);
    chk(dtrLine, 16'hFF00);
    chk(chRxBit, 16'h12F4);
    chk(chDcdOn, 16'hF0F0);
    $display("serial done");
  endtask
  task completeRun;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errTotal++;
      completeRun;
    end
  end
  // Main sequence
  initial
  begin
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    tIdle;
    tLines;
    tPrio;
    tArb;
    tSerial;
    completeRun;
  end
endmodule // tb
